// ==== lmsci_pkg.sv ====
package lmsci_pkg;
  // ===========================================================
  // register indices; byte address is four times the index
  localparam logic [7:0] IDX_STATUS = 8'h60;
  localparam logic [7:0] IDX_DATA = 8'h61;
  localparam logic [7:0] IDX_BAUD = 8'h62;
  localparam logic [7:0] IDX_CTRL1 = 8'h63;
  localparam logic [7:0] IDX_CTRL2 = 8'h64;
  localparam logic [7:0] IDX_CTRL3 = 8'h65;
  localparam logic [7:0] IDX_ERX = 8'h66;
  localparam logic [7:0] IDX_ETX = 8'h67;
  // ===========================================================
  // reset values
  localparam logic [7:0] RST_STATUS = 8'hC0;
  localparam logic [7:0] RST_ZERO = 8'h00;
  // ===========================================================
  // field positions
  localparam int CR1_R8 = 7;
  localparam int CR1_T8 = 6;
  localparam int CR1_M = 4;
  localparam int CR1_WAKE = 3;
  localparam int CR2_TE = 3;
  localparam int CR2_RE = 2;
  localparam int CR2_RWU = 1;
  localparam int CR2_SBK = 0;
  localparam int CR3_LIN = 6;
  localparam int CR3_SYNC_CLOCK_OUT_ENABLE = 3;
  localparam int CR3_CLOCK_IDLE_LEVEL = 2;
  localparam int CR3_CLOCK_EDGE_PHASE = 1;
  localparam int CR3_LAST_BIT_PULSE_ENABLE = 0;
  localparam logic [7:0] CR3_WMASK = 8'h4F;
  // ===========================================================
  // break lengths and clock pulse counts
  localparam logic [3:0] BRK_LEN_8 = 4'hA;
  localparam logic [3:0] BRK_LEN_9 = 4'hB;
  localparam logic [3:0] BRK_LEN_LIN8 = 4'hD;
  localparam logic [3:0] BRK_LEN_LIN9 = 4'hE;
  localparam logic [3:0] PULSES_7 = 4'h7;
  localparam logic [3:0] PULSES_8 = 4'h8;
  localparam logic [3:0] PULSES_9 = 4'h9;
  // coarse prescale factors
  localparam logic [3:0] PR_F0 = 4'h1;
  localparam logic [3:0] PR_F1 = 4'h3;
  localparam logic [3:0] PR_F2 = 4'h4;
  localparam logic [3:0] PR_F3 = 4'hD;
  // oversampling counts
  localparam logic [3:0] OVS_LAST = 4'hF;
  localparam logic [3:0] OVS_MID = 4'h7;
  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;
  typedef enum logic [2:0] {
    TX_IDLE = 3'b000, TX_START = 3'b001, TX_DATA = 3'b010,
    TX_STOP = 3'b011, TX_BRK = 3'b100, TX_BSTOP = 3'b101
  } lmsci_tx_e;
  typedef enum logic [1:0] {
    RX_IDLE = 2'b00, RX_START = 2'b01, RX_DATA = 2'b10, RX_STOP = 2'b11
  } lmsci_rx_e;
endpackage : lmsci_pkg

// ==== lmsci_top.sv ====
// The address map and register access over AXI4-Lite were left to the implementer.
`timescale 1ns/1ps
// Overview of operation
// - mute bit locked when address-mark and ready
// - send-break high keeps sending break characters
// - break pulse sends one break after word
// - control-three bit 6 enables LIN break
// - break low 10/11/13/14 bits by mode
// - control-three bits 5:4 read zero
// - bit 3 enables sync clock pin
// - polarity sets idle clock level
// - phase puts edge mid or start bit
// - pulse count 7/8/8/9 by length, last-bit
// - last-bit option gates final data pulse
// - data address splits transmit and receive holding
// - coarse code selects 1, 3, 4, 13
// - transmit code gives two to the power
// - receive code gives two to the power
// - nonzero extended transmit multiplies transmit factor
// - nonzero extended receive multiplies receive factor
// - extended receive divides sixteen stage output
// - extended receive prescaler clears at reset
// - extended transmit divides sixteen stage output
// - word length bit picks 8 or 9
module lmsci_top import lmsci_pkg::*; #(
  parameter int ADDR_W = 12
) (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // axi4-lite write
  input wire logic [ADDR_W-1:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  // axi4-lite read
  input wire logic [ADDR_W-1:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  // serial line
  input wire logic rxd,
  output logic txd,
  output logic sclk,
  output logic sclk_oe
);
  initial begin
    if (ADDR_W < 10) $error("ADDR_W must reach the register indices");
  end
  // ===========================================================
  // bus slave
  logic aw_hold_q, w_hold_q;
  logic [7:0] aw_idx_q, wd_q;
  logic wstrb0_q;
  logic rd_pend_q;
  logic [7:0] rd_idx_q;
  logic [7:0] status_q, data_rx_q, tx_hold_q, baud_q, cr1_q, cr2_q;
  logic [7:0] cr3_q, erx_q, etx_q;
  logic sr_seen_q;
  wire [7:0] aw_idx = aw_hold_q ? aw_idx_q : awaddr[9:2];
  wire [7:0] w_byte = w_hold_q ? wd_q : wdata[7:0];
  wire w_en0 = w_hold_q ? wstrb0_q : wstrb[0];
  wire aw_ok = aw_hold_q | awvalid;
  wire w_ok = w_hold_q | wvalid;
  wire wr_go = aw_ok & w_ok & ~bvalid;
  wire wr_hit = aw_idx >= IDX_STATUS && aw_idx <= IDX_ETX;
  wire wr_en = wr_go & w_en0;
  wire wr_data = wr_en & aw_idx == IDX_DATA;
  wire wr_baud = wr_en & aw_idx == IDX_BAUD;
  wire wr_cr1 = wr_en & aw_idx == IDX_CTRL1;
  wire wr_cr2 = wr_en & aw_idx == IDX_CTRL2;
  wire wr_cr3 = wr_en & aw_idx == IDX_CTRL3;
  wire wr_erx = wr_en & aw_idx == IDX_ERX;
  wire wr_etx = wr_en & aw_idx == IDX_ETX;
  wire rd_go = arvalid & arready;
  wire [7:0] ar_idx = araddr[9:2];
  wire rd_hit = ar_idx >= IDX_STATUS && ar_idx <= IDX_ETX;
  wire rd_status = rd_go & ar_idx == IDX_STATUS;
  wire rd_data = rd_go & ar_idx == IDX_DATA;
  // bits 7 and 5:4 stored as zero, so control three reads them as zero
  wire [7:0] cr3_rd = cr3_q & CR3_WMASK;
  logic [7:0] rd_mux;
  always_comb begin
    case (ar_idx)
      IDX_STATUS: rd_mux = status_q;
      IDX_DATA: rd_mux = data_rx_q;
      IDX_BAUD: rd_mux = baud_q;
      IDX_CTRL1: rd_mux = cr1_q;
      IDX_CTRL2: rd_mux = cr2_q;
      IDX_CTRL3: rd_mux = cr3_rd;
      IDX_ERX: rd_mux = erx_q;
      IDX_ETX: rd_mux = etx_q;
      default: rd_mux = RST_ZERO;
    endcase
  end
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_hold_q <= 1'b0;
      w_hold_q <= 1'b0;
      aw_idx_q <= RST_ZERO;
      wd_q <= RST_ZERO;
      wstrb0_q <= 1'b0;
      bvalid <= 1'b0;
      bresp <= RESP_OKAY;
    end else begin
      if (awvalid & awready) aw_idx_q <= awaddr[9:2];
      if (wvalid & wready) begin
        wd_q <= wdata[7:0];
        wstrb0_q <= wstrb[0];
      end
      aw_hold_q <= (aw_hold_q | (awvalid & awready)) & ~wr_go;
      w_hold_q <= (w_hold_q | (wvalid & wready)) & ~wr_go;
      if (wr_go) begin
        bvalid <= 1'b1;
        bresp <= wr_hit ? RESP_OKAY : RESP_SLVERR;
      end else if (bready) begin
        bvalid <= 1'b0;
      end
    end
  end
  // each ready only while its own channel holds nothing, so a held item waits its partner
  assign awready = ~aw_hold_q & ~bvalid;
  assign wready = ~w_hold_q & ~bvalid;
  assign arready = ~rvalid;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid <= 1'b0;
      rdata <= 32'h0000_0000;
      rresp <= RESP_OKAY;
      rd_pend_q <= 1'b0;
      rd_idx_q <= RST_ZERO;
    end else begin
      rd_pend_q <= 1'b0;
      if (rd_go) begin
        rvalid <= 1'b1;
        rdata <= {24'h00_0000, rd_mux};
        rresp <= rd_hit ? RESP_OKAY : RESP_SLVERR;
        rd_pend_q <= 1'b1;
        rd_idx_q <= ar_idx;
      end else if (rready) begin
        rvalid <= 1'b0;
      end
    end
  end
  // ===========================================================
  // baud generation
  wire word9 = cr1_q[CR1_M];
  wire lin_on = cr3_q[CR3_LIN];
  logic [3:0] pr_fac;
  always_comb begin
    case (baud_q[7:6])
      2'b00: pr_fac = PR_F0;
      2'b01: pr_fac = PR_F1;
      2'b10: pr_fac = PR_F2;
      default: pr_fac = PR_F3;
    endcase
  end
  logic [3:0] pr_cnt_q;
  wire pr_tick = pr_cnt_q >= pr_fac - 4'h1;
  always_ff @(posedge aclk) begin
    // restart on a new divisor so the first gap is already whole
    if (!aresetn | wr_baud) pr_cnt_q <= 4'h0;
    else pr_cnt_q <= pr_tick ? 4'h0 : pr_cnt_q + 4'h1;
  end
  // index 0 transmit, 1 receive; ticks run at sixteen times bit rate
  logic [1:0] ovs_tick;
  logic [14:0] div_total [2];
  genvar g;
  generate
    for (g = 0; g < 2; g++) begin : g_div
      wire [2:0] code = g == 0 ? baud_q[5:3] : baud_q[2:0];
      wire [7:0] ext = g == 0 ? etx_q : erx_q;
      wire [7:0] fac = 8'h01 << code;
      // zero extension falls back to the plain factor
      wire [15:0] prod = fac * (ext == 8'h00 ? 8'h01 : ext);
      logic [14:0] cnt_q;
      assign div_total[g] = prod[14:0];
      assign ovs_tick[g] = pr_tick & (cnt_q >= prod[14:0] - 15'h0001);
      always_ff @(posedge aclk) begin
        if (!aresetn) cnt_q <= 15'h0000;
        else if (ovs_tick[g]) cnt_q <= 15'h0000;
        else if (pr_tick) cnt_q <= cnt_q + 15'h0001;
      end
    end
  endgenerate
  wire tx_tick = ovs_tick[0];
  wire rx_tick = ovs_tick[1];
  // ===========================================================
  // transmitter
  lmsci_tx_e tx_st_q, tx_st_d;
  logic [3:0] tx_cnt_q, tx_bit_q;
  logic [8:0] tx_sh_q;
  logic brk_pend_q;
  wire [3:0] nbits = word9 ? 4'h9 : 4'h8;
  wire [3:0] brk_len = lin_on ? (word9 ? BRK_LEN_LIN9 : BRK_LEN_LIN8)
                              : (word9 ? BRK_LEN_9 : BRK_LEN_8);
  wire tx_on = cr2_q[CR2_TE];
  wire send_break = cr2_q[CR2_SBK];
  wire bit_end = tx_tick & tx_cnt_q == OVS_LAST;
  wire tdre = status_q[7];
  always_comb begin
    tx_st_d = tx_st_q;
    case (tx_st_q)
      TX_IDLE: begin
        // leave idle only on a tick, else the first bit comes short
        if (tx_tick & tx_on & (send_break | brk_pend_q)) tx_st_d = TX_BRK;
        else if (tx_tick & tx_on & ~tdre) tx_st_d = TX_START;
      end
      TX_START: if (bit_end) tx_st_d = TX_DATA;
      TX_DATA: if (bit_end & tx_bit_q == nbits - 4'h1) tx_st_d = TX_STOP;
      TX_STOP: if (bit_end) tx_st_d = TX_IDLE;
      TX_BRK: if (bit_end & tx_bit_q == brk_len - 4'h1) tx_st_d = TX_BSTOP;
      TX_BSTOP: if (bit_end) tx_st_d = TX_IDLE;
      default: tx_st_d = TX_IDLE;
    endcase
  end
  wire tx_load = tx_st_q == TX_IDLE & tx_st_d == TX_START;
  wire frame_done = tx_st_q == TX_STOP & tx_st_d == TX_IDLE;
  wire txd_d = tx_st_q == TX_START || tx_st_q == TX_BRK ? 1'b0 :
               tx_st_q == TX_DATA ? tx_sh_q[0] : 1'b1;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      tx_st_q <= TX_IDLE;
      tx_cnt_q <= 4'h0;
      tx_bit_q <= 4'h0;
      tx_sh_q <= 9'h1FF;
      txd <= 1'b1;
    end else begin
      tx_st_q <= tx_st_d;
      txd <= txd_d;
      if (tx_st_q == TX_IDLE) begin
        tx_cnt_q <= 4'h0;
        tx_bit_q <= 4'h0;
      end else if (tx_tick) begin
        tx_cnt_q <= tx_cnt_q + 4'h1;
        if (tx_st_d != tx_st_q) tx_bit_q <= 4'h0;
        else if (bit_end) tx_bit_q <= tx_bit_q + 4'h1;
      end
      if (tx_load) tx_sh_q <= {cr1_q[CR1_T8], tx_hold_q};
      else if (tx_st_q == TX_DATA & bit_end) tx_sh_q <= tx_sh_q >> 1;
    end
  end
  // a set-then-clear pulse is remembered until the break starts
  always_ff @(posedge aclk) begin
    if (!aresetn) brk_pend_q <= 1'b0;
    else if (wr_cr2 & w_byte[CR2_SBK]) brk_pend_q <= 1'b1;
    else if (tx_st_q == TX_BRK) brk_pend_q <= 1'b0;
  end
  // ===========================================================
  // synchronous clock output
  wire clock_idle_level = cr3_q[CR3_CLOCK_IDLE_LEVEL];
  wire pulse_bit = tx_bit_q != nbits - 4'h1 | cr3_q[CR3_LAST_BIT_PULSE_ENABLE];
  wire half2 = tx_cnt_q[3];
  wire sclk_act = tx_st_q == TX_DATA & cr3_q[CR3_SYNC_CLOCK_OUT_ENABLE] & pulse_bit;
  wire sclk_d = clock_idle_level ^ (sclk_act & (cr3_q[CR3_CLOCK_EDGE_PHASE] ? ~half2 : half2));
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sclk <= 1'b0;
      sclk_oe <= 1'b0;
    end else begin
      sclk <= sclk_d;
      sclk_oe <= cr3_q[CR3_SYNC_CLOCK_OUT_ENABLE];
    end
  end
  // ===========================================================
  // receiver
  lmsci_rx_e rx_st_q;
  logic [3:0] rx_cnt_q, rx_bit_q;
  logic [8:0] rx_sh_q;
  logic [7:0] idle_cnt_q;
  wire rx_on = cr2_q[CR2_RE];
  wire rx_mute = cr2_q[CR2_RWU];
  wire [8:0] rx_word = word9 ? rx_sh_q : {1'b0, rx_sh_q[8:1]};
  wire rx_msb = word9 ? rx_sh_q[8] : rx_sh_q[8];
  wire rx_end = rx_st_q == RX_STOP & rx_tick & rx_cnt_q == OVS_LAST;
  wire addr_wake = rx_end & rx_mute & cr1_q[CR1_WAKE] & rx_msb;
  wire rx_deliver = rx_end & (~rx_mute | addr_wake);
  wire [7:0] idle_len = {word9 ? BRK_LEN_9 : BRK_LEN_8, 4'h0};
  wire idle_seen = rx_tick & rx_st_q == RX_IDLE & idle_cnt_q == idle_len;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rx_st_q <= RX_IDLE;
      rx_cnt_q <= 4'h0;
      rx_bit_q <= 4'h0;
      rx_sh_q <= 9'h000;
      idle_cnt_q <= 8'h00;
    end else if (!rx_on) begin
      rx_st_q <= RX_IDLE;
      idle_cnt_q <= 8'h00;
    end else if (rx_tick) begin
      rx_cnt_q <= rx_cnt_q + 4'h1;
      case (rx_st_q)
        RX_IDLE: begin
          rx_cnt_q <= 4'h0;
          if (!rxd) rx_st_q <= RX_START;
          if (!rxd) idle_cnt_q <= 8'h00;
          else if (idle_cnt_q <= idle_len) idle_cnt_q <= idle_cnt_q + 8'h01;
        end
        RX_START: if (rx_cnt_q == OVS_MID) begin
          rx_st_q <= rxd ? RX_IDLE : RX_DATA;
          rx_cnt_q <= 4'h0;
          rx_bit_q <= 4'h0;
        end
        RX_DATA: if (rx_cnt_q == OVS_LAST) begin
          rx_sh_q <= {rxd, rx_sh_q[8:1]};
          rx_bit_q <= rx_bit_q + 4'h1;
          if (rx_bit_q == nbits - 4'h1) rx_st_q <= RX_STOP;
        end
        RX_STOP: if (rx_cnt_q == OVS_LAST) rx_st_q <= RX_IDLE;
        default: rx_st_q <= RX_IDLE;
      endcase
    end
  end
  // ===========================================================
  // control, data and status registers
  wire rx_ready_flag = status_q[5];
  wire rwu_lock = cr1_q[CR1_WAKE] & rx_ready_flag;
  wire sr_clr_rd = sr_seen_q & rd_data;
  wire sr_clr_wr = sr_seen_q & wr_data;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      baud_q <= RST_ZERO;
      cr1_q <= RST_ZERO;
      cr2_q <= RST_ZERO;
      cr3_q <= RST_ZERO;
      erx_q <= RST_ZERO;
      etx_q <= RST_ZERO;
      tx_hold_q <= RST_ZERO;
      data_rx_q <= RST_ZERO;
    end else begin
      if (wr_baud) baud_q <= w_byte;
      if (wr_erx) erx_q <= w_byte;
      if (wr_etx) etx_q <= w_byte;
      if (wr_cr3) cr3_q <= w_byte & CR3_WMASK;
      if (wr_data) tx_hold_q <= w_byte;
      if (rx_deliver & ~rx_ready_flag) data_rx_q <= rx_word[7:0];
      if (rx_deliver & ~rx_ready_flag) cr1_q[CR1_R8] <= rx_word[8];
      if (wr_cr1) cr1_q[6:0] <= w_byte[6:0];
      if (wr_cr2) cr2_q[7:2] <= w_byte[7:2];
      if (wr_cr2) cr2_q[CR2_SBK] <= w_byte[CR2_SBK];
      // hardware wake-up clears mute; a refused write leaves it
      if ((idle_seen & ~cr1_q[CR1_WAKE]) | addr_wake) cr2_q[CR2_RWU] <= 1'b0;
      else if (wr_cr2 & ~rwu_lock) cr2_q[CR2_RWU] <= w_byte[CR2_RWU];
    end
  end
  // status: tdre tc rx_ready_flag idle or 0 fe 0; set wins over clear
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      status_q <= RST_STATUS;
      sr_seen_q <= 1'b0;
    end else begin
      if (rd_status) sr_seen_q <= 1'b1;
      else if (rd_data | wr_data) sr_seen_q <= 1'b0;
      if (tx_load) status_q[7] <= 1'b1;
      else if (sr_clr_wr) status_q[7] <= 1'b0;
      if (frame_done) status_q[6] <= 1'b1;
      else if (sr_clr_wr) status_q[6] <= 1'b0;
      if (rx_deliver) status_q[5] <= 1'b1;
      else if (sr_clr_rd) status_q[5] <= 1'b0;
      if (idle_seen & rx_ready_flag) status_q[4] <= 1'b1;
      else if (sr_clr_rd) status_q[4] <= 1'b0;
      if (rx_deliver & rx_ready_flag) status_q[3] <= 1'b1;
      else if (sr_clr_rd) status_q[3] <= 1'b0;
      if (rx_deliver & ~rx_ready_flag & ~rxd) status_q[1] <= 1'b1;
      else if (sr_clr_rd) status_q[1] <= 1'b0;
    end
  end
  // ===========================================================
  // checks
  logic [3:0] pulse_q;
  logic [3:0] pr_gap_q;
  always_ff @(posedge aclk) begin
    if (!aresetn | tx_st_q == TX_START) pulse_q <= 4'h0;
    else if (sclk != clock_idle_level & sclk_d == sclk) pulse_q <= pulse_q;
    else if (sclk_d != clock_idle_level & sclk == clock_idle_level) pulse_q <= pulse_q + 4'h1;
    if (!aresetn | pr_tick | wr_baud) pr_gap_q <= 4'h0;
    else pr_gap_q <= pr_gap_q + 4'h1;
  end
  wire [3:0] pulses_exp = word9 ? (cr3_q[CR3_LAST_BIT_PULSE_ENABLE] ? PULSES_9 : PULSES_8)
                                : (cr3_q[CR3_LAST_BIT_PULSE_ENABLE] ? PULSES_8 : PULSES_7);
  a_mute_lock: assert property (@(posedge aclk) disable iff (!aresetn)
    wr_cr2 & rwu_lock & ~addr_wake & ~idle_seen |=> $stable(cr2_q[CR2_RWU]))
    else $error("mute bit changed while locked");
  a_break_low: assert property (@(posedge aclk) disable iff (!aresetn)
    tx_st_q == TX_BRK |=> txd == 1'b0)
    else $error("break bit not driven low");
  a_break_len: assert property (@(posedge aclk) disable iff (!aresetn)
    tx_st_q == TX_BRK & tx_st_d == TX_BSTOP |->
    tx_bit_q == (lin_on ? (word9 ? 4'hE : 4'hD) : (word9 ? 4'hB : 4'hA)) - 4'h1)
    else $error("break length wrong");
  a_res_zero: assert property (@(posedge aclk) disable iff (!aresetn)
    rvalid & rd_idx_q == IDX_CTRL3 |-> rdata[5:4] == 2'b00 || !rd_pend_q)
    else $error("reserved bits read nonzero");
  a_sclk_off: assert property (@(posedge aclk) disable iff (!aresetn)
    !cr3_q[CR3_SYNC_CLOCK_OUT_ENABLE] |=> !sclk_oe)
    else $error("clock pin enabled while off");
  a_sclk_idle: assert property (@(posedge aclk) disable iff (!aresetn)
    tx_st_q == TX_IDLE && $past(tx_st_q) == TX_IDLE && $stable(clock_idle_level)
    |-> sclk == clock_idle_level)
    else $error("clock idle level wrong");
  a_pulse_count: assert property (@(posedge aclk) disable iff (!aresetn)
    frame_done & cr3_q[CR3_SYNC_CLOCK_OUT_ENABLE] & $stable(cr3_q) |-> pulse_q == pulses_exp)
    else $error("clock pulse count wrong");
  a_coarse_gap: assert property (@(posedge aclk) disable iff (!aresetn)
    pr_tick & $past(pr_tick) == 1'b0 & !$past(wr_baud) & $stable(baud_q)
    |-> pr_gap_q == pr_fac - 4'h1)
    else $error("coarse prescale spacing wrong");
  a_hold_split: assert property (@(posedge aclk) disable iff (!aresetn)
    wr_data & ~rx_deliver |=> $stable(data_rx_q))
    else $error("data write altered receive holding");
  a_ext_reset: assert property (@(posedge aclk)
    $past(!aresetn) |-> erx_q == 8'h00)
    else $error("extended receive prescaler not cleared");
endmodule : lmsci_top

// ==== lmsci_node_model.sv ====
`timescale 1ns/1ps
module lmsci_node_model (
  // clock
  input wire logic aclk,
  // serial line
  input wire logic txd,
  input wire logic sclk,
  output logic rxd
);
  int run = 0;
  int last_low = 0;
  int lows = 0;
  int rises = 0;
  int falls = 0;
  logic sclk_p = 1'b0;
  // pulled-up line: idle high between frames
  initial rxd = 1'b1;
  // ==========================================================
  // line monitor: low-run length in clocks, clock edge counts
  always @(posedge aclk) begin
    sclk_p <= sclk;
    if (sclk && !sclk_p) rises <= rises + 1;
    if (!sclk && sclk_p) falls <= falls + 1;
    if (!txd) run <= run + 1;
    else if (run != 0) begin
      last_low <= run;
      lows <= lows + 1;
      run <= 0;
    end
  end
  // ==========================================================
  // frame sender, bc clocks per bit
  task automatic send(input logic [7:0] d, input int bc);
    logic [9:0] f;
    f = {1'b1, d, 1'b0};
    for (int i = 0; i < 10; i++) begin
      @(posedge aclk);
      rxd <= f[i];
      repeat (bc - 1) @(posedge aclk);
    end
  endtask : send
endmodule : lmsci_node_model

// ==== testbench.sv ====
`timescale 1ns/1ps
module testbench;
  import lmsci_pkg::*;
  logic aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
  logic arvalid, arready, rvalid, rready, rxd, txd, sclk, sclk_oe;
  logic [11:0] awaddr, araddr;
  logic [31:0] wdata, rdata, rv;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp, rr, wb;
  int error_cnt = 0;
  int num_checks = 0;
  int cyc = 0;
  int n, m;
  logic [7:0] rxb [0:2] = '{8'h03, 8'h01, 8'h40};
  logic [7:0] rxe [0:2] = '{8'h00, 8'h05, 8'h00};
  logic [7:0] rxv [0:2] = '{8'hA5, 8'h3C, 8'h96};
  int rxc [0:2] = '{128, 160, 48};
  int rxt [0:2] = '{16, 16, 48};
  logic [7:0] txb [0:6] = '{8'h00, 8'h40, 8'h80, 8'hC0, 8'h28, 8'h08, 8'hC8};
  logic [7:0] txe [0:6] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h03, 8'h02};
  int txc [0:6] = '{16, 48, 64, 208, 512, 96, 832};
  int bkl [0:3] = '{10, 11, 13, 14};
  int pls [0:3] = '{7, 8, 8, 9};

  lmsci_top dut (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr),
    .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb),
    .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid),
    .bready(bready), .araddr(araddr), .arvalid(arvalid),
    .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
    .rready(rready), .rxd(rxd), .txd(txd), .sclk(sclk),
    .sclk_oe(sclk_oe));
  lmsci_node_model node (.aclk(aclk), .txd(txd), .sclk(sclk), .rxd(rxd));

  initial begin
    aclk = 1'b0;
    forever #10 aclk = ~aclk;
  end
  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (cyc == 80000) begin
      error_cnt++;
      end_sim();
    end
  end
  // ==========================================================
  // helpers
  task end_sim;
    $display("checks %0d errors %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : end_sim
  task chk(input logic [31:0] g, input logic [31:0] e);
    num_checks++;
    if (g !== e) begin
      error_cnt++;
      $display("CHECK FAILED t=%0t got %h exp %h", $time, g, e);
    end
  endtask : chk
  task automatic wr(input logic [7:0] i, input logic [7:0] d);
    logic ta, tw, tb;
    awaddr <= {2'b00, i, 2'b00};
    wdata <= {24'h0, d};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    tb = 1'b0;
    while (!tb) begin
      @(negedge aclk);
      ta = awready & awvalid;
      tw = wready & wvalid;
      tb = bvalid;
      wb = bresp;
      @(posedge aclk);
      if (ta) awvalid <= 1'b0;
      if (tw) wvalid <= 1'b0;
    end
    // bready stays high: a drop here would meet the next call's raise
  endtask : wr
  task automatic rd(input logic [7:0] i);
    logic ta, tr;
    araddr <= {2'b00, i, 2'b00};
    arvalid <= 1'b1;
    rready <= 1'b1;
    tr = 1'b0;
    while (!tr) begin
      @(negedge aclk);
      ta = arready & arvalid;
      tr = rvalid;
      rv = rdata;
      rr = rresp;
      @(posedge aclk);
      if (ta) arvalid <= 1'b0;
    end
  endtask : rd
  task rck(input logic [7:0] i, input logic [7:0] e);
    rd(i);
    chk(rv, {24'h0, e});
  endtask : rck
  task wlow;
    n = node.lows;
    while (node.lows == n) @(posedge aclk);
  endtask : wlow
  // status access first, else the data write does not start a frame
  task txff;
    rd(IDX_STATUS);
    wr(IDX_DATA, 8'hFF);
  endtask : txff
  // ==========================================================
  // main sequence
  initial begin
    aresetn = 1'b0;
    {awvalid, wvalid, bready, arvalid, rready} = 5'h00;
    awaddr = 12'h000;
    araddr = 12'h000;
    wdata = 32'h0;
    wstrb = 4'hF;
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    rck(IDX_STATUS, RST_STATUS);
    rck(IDX_BAUD, 8'h00);
    rck(IDX_CTRL3, 8'h00);
    rck(IDX_ERX, 8'h00);
    rck(IDX_ETX, 8'h00);
    chk(32'(sclk_oe), 32'h0);
    rd(8'h10);
    chk(32'(rr), 32'(RESP_SLVERR));
    wr(8'h10, 8'h00);
    chk(32'(wb), 32'(RESP_SLVERR));
    wr(IDX_CTRL3, 8'h3F);
    chk(32'(wb), 32'(RESP_OKAY));
    rck(IDX_CTRL3, 8'h0F);
    chk(32'(rr), 32'(RESP_OKAY));
    wr(IDX_CTRL3, 8'h00);
    // address-mark wake, receiver and transmitter on
    wr(IDX_CTRL1, 8'h08);
    wr(IDX_CTRL2, 8'h0C);
    for (int i = 0; i < 3; i++) begin
      wr(IDX_BAUD, rxb[i]);
      wr(IDX_ERX, rxe[i]);
      node.send(rxv[i], rxc[i]);
      repeat (rxc[i]) @(posedge aclk);
      wr(IDX_CTRL2, 8'h0E);
      rck(IDX_CTRL2, 8'h0C);
      txff();
      wlow();
      chk(node.last_low, rxt[i]);
      rd(IDX_STATUS);
      rck(IDX_DATA, rxv[i]);
      repeat (11 * rxt[i]) @(posedge aclk);
    end
    wr(IDX_CTRL2, 8'h0E);
    rck(IDX_CTRL2, 8'h0E);
    wr(IDX_CTRL2, 8'h0C);
    wr(IDX_CTRL1, 8'h00);
    wr(IDX_ERX, 8'h00);
    // transmit rates, measured on the start bit of an all-ones word
    for (int i = 0; i < 7; i++) begin
      wr(IDX_BAUD, txb[i]);
      wr(IDX_ETX, txe[i]);
      txff();
      wlow();
      chk(node.last_low, txc[i]);
      repeat (11 * txc[i]) @(posedge aclk);
    end
    wr(IDX_ETX, 8'h00);
    wr(IDX_BAUD, 8'h00);
    // held break repeats; length by word size and line mode
    for (int i = 0; i < 4; i++) begin
      wr(IDX_CTRL1, i[0] ? 8'h10 : 8'h00);
      wr(IDX_CTRL3, i[1] ? 8'h40 : 8'h00);
      wr(IDX_CTRL2, 8'h0D);
      wlow();
      chk(node.last_low, 16 * bkl[i]);
      wlow();
      chk(node.last_low, 16 * bkl[i]);
      wr(IDX_CTRL2, 8'h0C);
      repeat (16 * 40) @(posedge aclk);
    end
    wr(IDX_CTRL1, 8'h00);
    wr(IDX_CTRL3, 8'h00);
    // set-then-clear during a word: one break after it
    txff();
    wr(IDX_CTRL2, 8'h0D);
    wr(IDX_CTRL2, 8'h0C);
    wlow();
    chk(node.last_low, 16);
    wlow();
    chk(node.last_low, 160);
    m = node.lows;
    repeat (16 * 30) @(posedge aclk);
    chk(node.lows, m);
    // synchronous clock: pulse counts and idle level
    for (int i = 0; i < 4; i++) begin
      wr(IDX_CTRL2, 8'h04);
      wr(IDX_CTRL1, i[1] ? 8'h10 : 8'h00);
      wr(IDX_CTRL3, {4'h0, 1'b1, i[0], i[1], i[0]});
      wr(IDX_CTRL2, 8'h0C);
      m = i[0] ? node.falls : node.rises;
      txff();
      wlow();
      repeat (16 * 11) @(posedge aclk);
      chk((i[0] ? node.falls : node.rises) - m, pls[i]);
      chk(32'(sclk), 32'(i[0]));
      chk(32'(sclk_oe), 32'h1);
    end
    wr(IDX_CTRL2, 8'h04);
    wr(IDX_CTRL3, 8'h00);
    repeat (2) @(posedge aclk);
    chk(32'(sclk_oe), 32'h0);
    end_sim();
  end
endmodule : testbench
